/* File: core/iers_alu.sv */
`timescale 1ns/1ps
module iers_alu (
  iers_alu_if.alu_mp bus
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  // ****************************************************************
  // Operand minus accumulator, carry means no borrow
  // ****************************************************************
  always_comb begin
    diff     = {1'b0, bus.operand} + {1'b0, ~bus.acc} + 9'h001;
    low_diff = {1'b0, bus.operand[3:0]} + {1'b0, ~bus.acc[3:0]} + 5'h01;
  end

  always_comb begin
    bus.result    = bus.operand;
    bus.carry_out = bus.carry_in;
    bus.half_out  = low_diff[4];
    unique case (bus.op)
      iers_pkg::ROTATE_RIGHT_CARRY_OP: begin
        bus.result    = {bus.carry_in, bus.operand[7:1]};
        bus.carry_out = bus.operand[0];
      end
      iers_pkg::LITERAL_MINUS_ACC_OP,
      iers_pkg::FILE_MINUS_ACC_OP: begin
        bus.result    = diff[7:0];
        bus.carry_out = diff[8];
      end
      iers_pkg::XOR_LITERAL_OP,
      iers_pkg::XOR_FILE_OP: begin
        bus.result = bus.operand ^ bus.acc;
      end
      iers_pkg::NIBBLE_EXCHANGE_OP: begin
        bus.result = {bus.operand[3:0], bus.operand[7:4]};
      end
      iers_pkg::RETURN_OP,
      iers_pkg::POWERDOWN_OP: begin
        bus.result = bus.operand;
      end
    endcase
    bus.null_out = (bus.result == 8'h00);
  end

endmodule

/* File: core/iers_alu_if.sv */
`timescale 1ns/1ps
interface iers_alu_if;
  iers_pkg::iers_op_type op;
  logic [7:0]            acc;
  logic [7:0]            operand;
  logic                  carry_in;
  logic [7:0]            result;
  logic                  carry_out;
  logic                  half_out;
  logic                  null_out;

  modport alu_mp (
    input  op,
    input  acc,
    input  operand,
    input  carry_in,
    output result,
    output carry_out,
    output half_out,
    output null_out
  );

  modport ctrl_mp (
    output op,
    output acc,
    output operand,
    output carry_in,
    input  result,
    input  carry_out,
    input  half_out,
    input  null_out
  );
endinterface

/* File: core/iers_core.sv */
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module iers_core (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             osc_halted
);

  // ****************************************************************
  // State
  // ****************************************************************
  iers_pkg::iers_state_type state_q;
  logic [7:0]               acc_q;
  logic                     carry_q;
  logic                     half_q;
  logic                     null_q;
  logic                     pdn_q;
  logic                     tmo_q;
  logic                     sleep_q;
  logic [iers_pkg::PC_W-1:0] pc_q;
  logic [iers_pkg::PC_W-1:0] stack_mem [iers_pkg::STACK_DEPTH];
  logic [iers_pkg::SP_W-1:0] sp_q;
  logic [7:0]               file_mem [iers_pkg::FILE_DEPTH];
  logic [7:0]               wdog_q;
  logic [7:0]               presc_q;
  logic [11:0]              instr_q;
  logic [31:0]              rdata_d;

  // ****************************************************************
  // Decode of the latched instruction
  // ****************************************************************
  iers_pkg::iers_op_type        op;
  logic                         dest_file;
  logic [7:0]                   literal;
  logic [iers_pkg::ADDR_W-1:0]  faddr;
  logic                         lit_form;
  logic                         uses_dest;
  logic [iers_pkg::SP_W-1:0]    sp_top;
  logic                         exec;
  logic                         is_file;
  logic [iers_pkg::ADDR_W-1:0]  bus_faddr;
  logic                         done_wr;

  assign op        = iers_pkg::iers_op_type'(instr_q[iers_pkg::OP_LSB +: iers_pkg::OP_W]);
  assign dest_file = instr_q[iers_pkg::DEST_BIT];
  assign literal   = instr_q[iers_pkg::OPND_LSB +: iers_pkg::OPND_W];
  assign faddr     = instr_q[iers_pkg::OPND_LSB +: iers_pkg::ADDR_W];
  assign lit_form  = (op == iers_pkg::LITERAL_MINUS_ACC_OP) || (op == iers_pkg::XOR_LITERAL_OP);
  assign uses_dest = (op == iers_pkg::ROTATE_RIGHT_CARRY_OP) || (op == iers_pkg::FILE_MINUS_ACC_OP)
                     || (op == iers_pkg::XOR_FILE_OP) || (op == iers_pkg::NIBBLE_EXCHANGE_OP);
  assign sp_top    = sp_q - 3'h1;
  assign exec      = (state_q == iers_pkg::ST_EXEC);
  assign is_file   = avs_address[iers_pkg::FILE_SEL_BIT];
  assign bus_faddr = avs_address[2 +: iers_pkg::ADDR_W];
  assign done_wr   = (state_q == iers_pkg::ST_DONE) && avs_write;

  // ****************************************************************
  // Arithmetic unit
  // ****************************************************************
  iers_alu_if alu_bus ();

  assign alu_bus.op       = op;
  assign alu_bus.acc      = acc_q;
  assign alu_bus.operand  = lit_form ? literal : file_mem[faddr];
  assign alu_bus.carry_in = carry_q;

  iers_alu u_alu (
    .bus (alu_bus)
  );

  // ****************************************************************
  // Bus sequencing: one access ends in ST_DONE
  // ****************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && (state_q != iers_pkg::ST_DONE);
  assign osc_halted      = sleep_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= iers_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        iers_pkg::ST_IDLE: begin
          if (avs_write && !is_file && avs_address == iers_pkg::INSTR_OFS && !sleep_q) begin
            state_q <= iers_pkg::ST_EXEC;
          end else if (avs_read || avs_write) begin
            state_q <= iers_pkg::ST_DONE;
          end
        end
        iers_pkg::ST_EXEC: begin
          if (op == iers_pkg::RETURN_OP) begin
            state_q <= iers_pkg::ST_RET2;
          end else begin
            state_q <= iers_pkg::ST_DONE;
          end
        end
        iers_pkg::ST_RET2: begin
          state_q <= iers_pkg::ST_DONE;
        end
        iers_pkg::ST_DONE: begin
          state_q <= iers_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Instruction word is latched in ST_IDLE, on the first cycle of the write
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      instr_q <= 12'h000;
    end else if (state_q == iers_pkg::ST_IDLE && avs_write && !is_file
                 && avs_address == iers_pkg::INSTR_OFS) begin
      instr_q <= avs_writedata[11:0];
    end
  end

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      acc_q <= iers_pkg::ACC_RST;
    end else if (exec && (lit_form || (uses_dest && !dest_file))) begin
      acc_q <= alu_bus.result;
    end else if (done_wr && !is_file && avs_address == iers_pkg::ACC_OFS) begin
      acc_q <= avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // File registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (exec && uses_dest && dest_file) begin
      file_mem[faddr] <= alu_bus.result;
    end else if (done_wr && is_file) begin
      file_mem[bus_faddr] <= avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // Arithmetic flags
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      carry_q <= 1'b0;
      half_q  <= 1'b0;
      null_q  <= 1'b0;
    end else if (exec) begin
      unique case (op)
        iers_pkg::ROTATE_RIGHT_CARRY_OP: begin
          carry_q <= alu_bus.carry_out;
        end
        iers_pkg::LITERAL_MINUS_ACC_OP,
        iers_pkg::FILE_MINUS_ACC_OP: begin
          carry_q <= alu_bus.carry_out;
          half_q  <= alu_bus.half_out;
          null_q  <= alu_bus.null_out;
        end
        iers_pkg::XOR_LITERAL_OP,
        iers_pkg::XOR_FILE_OP: begin
          null_q <= alu_bus.null_out;
        end
        iers_pkg::RETURN_OP,
        iers_pkg::POWERDOWN_OP,
        iers_pkg::NIBBLE_EXCHANGE_OP: begin
          carry_q <= carry_q;
        end
      endcase
    end else if (done_wr && !is_file && avs_address == iers_pkg::STATUS_OFS) begin
      carry_q <= avs_writedata[iers_pkg::CARRY_BIT];
      half_q  <= avs_writedata[iers_pkg::HALF_BIT];
      null_q  <= avs_writedata[iers_pkg::NULL_BIT];
    end
  end

  // ****************************************************************
  // Power-down, time-out and sleep
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pdn_q   <= iers_pkg::PDN_RST;
      tmo_q   <= iers_pkg::TMO_RST;
      sleep_q <= 1'b0;
    end else if (exec && op == iers_pkg::POWERDOWN_OP) begin
      pdn_q   <= 1'b0;
      tmo_q   <= 1'b1;
      sleep_q <= 1'b1;
    end else if (done_wr && !is_file && avs_address == iers_pkg::WAKE_OFS
                 && avs_writedata[0]) begin
      sleep_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Watchdog counter with prescaler
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wdog_q  <= iers_pkg::WDOG_RST;
      presc_q <= iers_pkg::PRESC_RST;
    end else if (exec && op == iers_pkg::POWERDOWN_OP) begin
      wdog_q  <= iers_pkg::WDOG_RST;
      presc_q <= iers_pkg::PRESC_RST;
    end else begin
      presc_q <= presc_q + 8'h01;
      if (presc_q == iers_pkg::PRESC_WRAP) begin
        wdog_q <= wdog_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Program counter and return stack
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pc_q <= '0;
      sp_q <= '0;
    end else if (exec && op == iers_pkg::RETURN_OP) begin
      pc_q <= stack_mem[sp_top];
      sp_q <= sp_top;
    end else if (exec) begin
      pc_q <= pc_q + 13'h0001;
    end else if (done_wr && !is_file && avs_address == iers_pkg::PC_OFS) begin
      pc_q <= avs_writedata[iers_pkg::PC_W-1:0];
    end else if (done_wr && !is_file && avs_address == iers_pkg::STACK_OFS) begin
      sp_q <= sp_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (done_wr && !is_file && avs_address == iers_pkg::STACK_OFS) begin
      stack_mem[sp_q] <= avs_writedata[iers_pkg::PC_W-1:0];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (is_file) begin
      rdata_d[7:0] = file_mem[bus_faddr];
    end else begin
      unique case (avs_address)
        iers_pkg::INSTR_OFS:  rdata_d[11:0] = instr_q;
        iers_pkg::ACC_OFS:    rdata_d[7:0]  = acc_q;
        iers_pkg::STATUS_OFS: begin
          rdata_d[iers_pkg::CARRY_BIT] = carry_q;
          rdata_d[iers_pkg::HALF_BIT]  = half_q;
          rdata_d[iers_pkg::NULL_BIT]  = null_q;
          rdata_d[iers_pkg::PDN_BIT]   = pdn_q;
          rdata_d[iers_pkg::TMO_BIT]   = tmo_q;
          rdata_d[iers_pkg::SLEEP_BIT] = sleep_q;
        end
        iers_pkg::PC_OFS:     rdata_d[iers_pkg::PC_W-1:0] = pc_q;
        iers_pkg::STACK_OFS:  rdata_d[iers_pkg::SP_W-1:0] = sp_q;
        iers_pkg::WDOG_OFS:   rdata_d[15:0] = {presc_q, wdog_q};
        default:              rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && state_q != iers_pkg::ST_DONE) begin
      avs_readdata <= rdata_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_rot_carry;
    exec && op == iers_pkg::ROTATE_RIGHT_CARRY_OP
      |=> carry_q == $past(alu_bus.operand[0]) && $stable(null_q) && $stable(half_q);
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");

  property p_rot_msb;
    exec && op == iers_pkg::ROTATE_RIGHT_CARRY_OP && !dest_file
      |=> acc_q == {$past(carry_q), $past(alu_bus.operand[7:1])};
  endproperty
  a_rot_msb: assert property (p_rot_msb) else $error("rotate result wrong");

  property p_dest_file;
    exec && uses_dest && dest_file |=> $stable(acc_q);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("acc changed on file dest");

  property p_dest_acc;
    exec && uses_dest && !dest_file |=> acc_q == $past(alu_bus.result);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("acc not loaded");

  property p_ret_pc;
    exec && op == iers_pkg::RETURN_OP
      |=> pc_q == $past(stack_mem[sp_top]) && sp_q == $past(sp_top) && $stable(carry_q);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong");

  property p_ret_two;
    exec && op == iers_pkg::RETURN_OP
      |=> state_q == iers_pkg::ST_RET2 ##1 state_q == iers_pkg::ST_DONE;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_sleep_flags;
    exec && op == iers_pkg::POWERDOWN_OP |=> !pdn_q && tmo_q && $stable({carry_q, half_q, null_q});
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("power-down flags wrong");

  property p_sleep_wdog;
    exec && op == iers_pkg::POWERDOWN_OP |=> wdog_q == 8'h00 && presc_q == 8'h00;
  endproperty
  a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared");

  property p_sleep_enter;
    exec && op == iers_pkg::POWERDOWN_OP |=> sleep_q && osc_halted;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

  property p_sub_lit;
    exec && op == iers_pkg::LITERAL_MINUS_ACC_OP
      |=> acc_q == 8'($past(literal) - $past(acc_q)) && carry_q == $past(literal >= acc_q);
  endproperty
  a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");

  property p_xor_flags;
    exec && (op == iers_pkg::XOR_LITERAL_OP || op == iers_pkg::XOR_FILE_OP)
      |=> $stable(carry_q) && $stable(half_q) && null_q == ($past(alu_bus.result) == 8'h00);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");

  property p_swap_flags;
    exec && op == iers_pkg::NIBBLE_EXCHANGE_OP
      |=> $stable(carry_q) && $stable(half_q) && $stable(null_q);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap touched flags");

  c_return:    cover property (exec && op == iers_pkg::RETURN_OP ##2 state_q == iers_pkg::ST_DONE);
  c_powerdown: cover property (exec && op == iers_pkg::POWERDOWN_OP ##1 sleep_q);
  c_sub_zero:  cover property (exec && op == iers_pkg::FILE_MINUS_ACC_OP ##1 null_q);

endmodule

/* File: core/iers_pkg.sv */
package iers_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [9:0] INSTR_OFS    = 10'h000;
  localparam logic [9:0] ACC_OFS      = 10'h004;
  localparam logic [9:0] STATUS_OFS   = 10'h008;
  localparam logic [9:0] PC_OFS       = 10'h00c;
  localparam logic [9:0] STACK_OFS    = 10'h010;
  localparam logic [9:0] WDOG_OFS     = 10'h014;
  localparam logic [9:0] WAKE_OFS     = 10'h018;
  localparam int         FILE_SEL_BIT = 9;

  // ****************************************************************
  // Instruction word fields
  // ****************************************************************
  localparam int OPND_LSB = 0;
  localparam int OPND_W   = 8;
  localparam int ADDR_W   = 7;
  localparam int DEST_BIT = 8;
  localparam int OP_LSB   = 9;
  localparam int OP_W     = 3;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int CARRY_BIT = 0;
  localparam int HALF_BIT  = 1;
  localparam int NULL_BIT  = 2;
  localparam int PDN_BIT   = 3;
  localparam int TMO_BIT   = 4;
  localparam int SLEEP_BIT = 5;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int         PC_W         = 13;
  localparam int         STACK_DEPTH  = 8;
  localparam int         SP_W         = 3;
  localparam int         FILE_DEPTH   = 128;
  localparam logic       PDN_RST      = 1'b1;
  localparam logic       TMO_RST      = 1'b1;
  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic [7:0] WDOG_RST     = 8'h00;
  localparam logic [7:0] PRESC_RST    = 8'h00;
  localparam logic [7:0] PRESC_WRAP   = 8'hff;

  typedef enum logic [2:0] {
    ROTATE_RIGHT_CARRY_OP = 3'b000,
    RETURN_OP             = 3'b001,
    POWERDOWN_OP          = 3'b010,
    LITERAL_MINUS_ACC_OP  = 3'b011,
    FILE_MINUS_ACC_OP     = 3'b100,
    XOR_LITERAL_OP        = 3'b101,
    XOR_FILE_OP           = 3'b110,
    NIBBLE_EXCHANGE_OP    = 3'b111
  } iers_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RET2 = 2'b10,
    ST_DONE = 2'b11
  } iers_state_type;

endpackage

/* File: tb/iers_core_test.sv */
`timescale 1ns/1ps
module iers_core_test;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic        core_clk      = 1'b0;
  logic        rstn          = 1'b0;
  logic [9:0]  avs_address   = 10'h000;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        osc_halted;
  int          n_mismatch    = 0;
  int          checks        = 0;
  int          cyc;
  logic [31:0] rd;
  logic [7:0]  kv [3]        = '{8'h05, 8'h00, 8'h10};
  logic [7:0]  av [3]        = '{8'h05, 8'h01, 8'h01};

  iers_core uut (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .osc_halted      (osc_halted)
  );

  always #5 core_clk = ~core_clk;

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic results();
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low; cyc counts edges
  task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    cyc = 0;
    do begin
      @(posedge core_clk);
      cyc++;
      if (cyc > 50) begin
        n_mismatch++;
        results();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic exec(input iers_pkg::iers_op_type op, input logic dst, input logic [7:0] v);
    access(1'b1, iers_pkg::INSTR_OFS, {20'h0, op, dst, v});
  endtask

  function automatic logic [9:0] fa(input int n);
    return 10'h200 + 10'(4 * n);
  endfunction

  // Status after a subtract x - y, with powerdown_flag and timeout_flag high
  function automatic logic [31:0] sub_st(input logic [7:0] x, input logic [7:0] y);
    logic [7:0] r;
    r = x - y;
    return {27'h0, 2'b11, r == 8'h00, x[3:0] >= y[3:0], x >= y};
  endfunction

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd_chk("status_rst", iers_pkg::STATUS_OFS, 32'h18);
    rd_chk("acc_rst", iers_pkg::ACC_OFS, 32'h0);
    rd_chk("unmapped", 10'h01c, 32'h0);
    access(1'b1, iers_pkg::STATUS_OFS, 32'h7);
    access(1'b1, fa(5), 32'h81);
    exec(iers_pkg::ROTATE_RIGHT_CARRY_OP, 1'b1, 8'd5);
    check("ord_cycles", 32'(cyc), 32'd3);
    rd_chk("rot_file", fa(5), 32'hc0);
    rd_chk("rot_st", iers_pkg::STATUS_OFS, 32'h1f);
    exec(iers_pkg::ROTATE_RIGHT_CARRY_OP, 1'b0, 8'd5);
    rd_chk("rot_acc", iers_pkg::ACC_OFS, 32'he0);
    rd_chk("rot_keep", fa(5), 32'hc0);
    rd_chk("rot_st2", iers_pkg::STATUS_OFS, 32'h1e);
    for (int i = 0; i < 3; i++) begin
      access(1'b1, iers_pkg::ACC_OFS, {24'h0, av[i]});
      exec(iers_pkg::LITERAL_MINUS_ACC_OP, 1'b1, kv[i]);
      rd_chk("lit_sub", iers_pkg::ACC_OFS, {24'h0, 8'(kv[i] - av[i])});
      rd_chk("lit_sub_st", iers_pkg::STATUS_OFS, sub_st(kv[i], av[i]));
    end
    access(1'b1, fa(127), 32'h30);
    access(1'b1, iers_pkg::ACC_OFS, 32'h31);
    exec(iers_pkg::FILE_MINUS_ACC_OP, 1'b1, 8'd127);
    rd_chk("fsub_file", fa(127), 32'hff);
    rd_chk("fsub_keep", iers_pkg::ACC_OFS, 32'h31);
    rd_chk("fsub_st", iers_pkg::STATUS_OFS, sub_st(8'h30, 8'h31));
    exec(iers_pkg::FILE_MINUS_ACC_OP, 1'b0, 8'd127);
    rd_chk("fsub_acc", iers_pkg::ACC_OFS, 32'hce);
    rd_chk("fsub_st2", iers_pkg::STATUS_OFS, sub_st(8'hff, 8'h31));
    exec(iers_pkg::XOR_LITERAL_OP, 1'b1, 8'hce);
    rd_chk("xorl_acc", iers_pkg::ACC_OFS, 32'h0);
    rd_chk("xorl_st", iers_pkg::STATUS_OFS, 32'h1f);
    exec(iers_pkg::XOR_FILE_OP, 1'b1, 8'd127);
    rd_chk("xorf_file", fa(127), 32'hff);
    rd_chk("xorf_st", iers_pkg::STATUS_OFS, 32'h1b);
    exec(iers_pkg::XOR_FILE_OP, 1'b0, 8'd127);
    rd_chk("xorf_acc", iers_pkg::ACC_OFS, 32'hff);
    exec(iers_pkg::NIBBLE_EXCHANGE_OP, 1'b1, 8'd5);
    rd_chk("swap_file", fa(5), 32'h0c);
    exec(iers_pkg::NIBBLE_EXCHANGE_OP, 1'b0, 8'd5);
    rd_chk("swap_acc", iers_pkg::ACC_OFS, 32'hc0);
    rd_chk("swap_st", iers_pkg::STATUS_OFS, 32'h1b);
    access(1'b1, iers_pkg::STACK_OFS, 32'h123);
    exec(iers_pkg::RETURN_OP, 1'b0, 8'h00);
    check("ret_cycles", 32'(cyc), 32'd4);
    rd_chk("ret_pc", iers_pkg::PC_OFS, 32'h123);
    rd_chk("ret_sp", iers_pkg::STACK_OFS, 32'h0);
    rd_chk("ret_st", iers_pkg::STATUS_OFS, 32'h1b);
    // Let the watchdog advance past zero before power-down
    repeat (600) @(posedge core_clk);
    exec(iers_pkg::POWERDOWN_OP, 1'b0, 8'h00);
    check("osc_halt", {31'h0, osc_halted}, 32'h1);
    rd_chk("sleep_st", iers_pkg::STATUS_OFS, 32'h33);
    access(1'b0, iers_pkg::WDOG_OFS, 32'h0);
    check("wdog_cnt", {24'h0, rd[7:0]}, 32'h0);
    check("wdog_presc", {31'h0, rd[15:8] < 8'h10}, 32'h1);
    exec(iers_pkg::XOR_LITERAL_OP, 1'b0, 8'hff);
    check("sleep_cycles", 32'(cyc), 32'd2);
    rd_chk("sleep_acc", iers_pkg::ACC_OFS, 32'hc0);
    access(1'b1, iers_pkg::WAKE_OFS, 32'h1);
    check("osc_run", {31'h0, osc_halted}, 32'h0);
    results();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
endmodule
